/* design/ptc_timer.sv */
module ptc_timer
    import ptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin,
    input wire logic capture_input_pin,
    input wire logic line_comparator_out,
    output logic timer_output_pin,
    output logic timer_output_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // state of the whole block

    typedef struct packed {
        ptc_ctrl0_t ctrl0;
        ptc_ctrl1_t ctrl1;
        ptc_ctrl2_t ctrl2;
        logic [9:0] counter;
        logic [9:0] compare_a_value;
        logic [9:0] compare_b_value;
        logic [9:0] period_value;
        logic input_source_select_reg;
        logic enable_prev;
        logic [1:0] div4;
        logic [5:0] div_high;
        logic [7:0] div_sub;
        logic ext_prev;
        logic trig_prev;
        logic out_level;
        logic pin;
        logic pin_oe;
        ptc_apb_resp_t resp;
    } ptc_state_t;

    ptc_state_t state;
    ptc_state_t next_state;

    // low byte of a ten-bit value
    function automatic logic [7:0] lo_byte(input logic [9:0] value);
        lo_byte = value[7:0];
    endfunction : lo_byte

    // high byte of a ten-bit value, upper bits zero
    function automatic logic [7:0] hi_byte(input logic [9:0] value);
        hi_byte = {6'h00, value[9:8]};
    endfunction : hi_byte

    ////////////////////////////////////////////////////////////////////////////
    // combinational next state

    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic trig;
    logic trig_rise;
    logic trig_fall;
    logic enable_rise;
    logic match_a;
    logic match_p;
    logic clear_counter;
    logic cap_to_a;
    logic cap_to_b;
    logic pwm_active;
    logic [9:0] limit;
    logic [7:0] rd;
    logic rd_ok;
    logic wr;

    always_comb begin
        next_state = state;

        // clock dividers run freely, each gives a one-cycle tick
        next_state.div4 = state.div4 + 2'h1;
        next_state.div_high = state.div_high + 6'h01;
        next_state.div_sub = (state.div_sub == SUB_DIV_LAST) ? 8'h00 : state.div_sub + 8'h01;
        next_state.ext_prev = ext_clock_pin;
        ext_rise = ext_clock_pin && !state.ext_prev;
        ext_fall = !ext_clock_pin && state.ext_prev;

        // counter clock source
        unique case (state.ctrl0.timer_clock_select) // see RL1
            CLK_SYS_DIV4: tick = (state.div4 == DIV4_LAST);
            CLK_SYS: tick = 1'b1;
            CLK_HIGH_DIV16: tick = (state.div_high[3:0] == DIV16_LAST[3:0]);
            CLK_HIGH_DIV64: tick = (state.div_high == DIV64_LAST);
            CLK_SUB_A, CLK_SUB_B: tick = (state.div_sub == SUB_DIV_LAST);
            CLK_EXT_RISE: tick = ext_rise;
            CLK_EXT_FALL: tick = ext_fall;
        endcase

        // capture trigger source and its edges
        if (state.ctrl1.capture_source_select) begin // see RL16
            trig = ext_clock_pin;
        end else if (state.input_source_select_reg) begin
            trig = line_comparator_out;
        end else begin
            trig = capture_input_pin;
        end
        next_state.trig_prev = trig;
        trig_rise = trig && !state.trig_prev;
        trig_fall = !trig && state.trig_prev;

        next_state.enable_prev = state.ctrl0.timer_enable;
        enable_rise = state.ctrl0.timer_enable && !state.enable_prev;

        // comparators on the full counter value
        match_a = (state.counter == state.compare_a_value); // see RL23
        match_p = (state.counter == state.period_value); // see RL23
        limit = (state.period_value == COUNTER_RESET) ? COUNTER_MAX : state.period_value;

        // clear condition for the counter
        clear_counter = 1'b0;
        unique case (state.ctrl1.op_mode_select) // see RL5
            MODE_COMPARE, MODE_TIMER: begin
                if (state.ctrl1.counter_clear_select) begin // see RL17
                    clear_counter = match_a;
                end else begin
                    clear_counter = (state.counter == limit); // see RL17
                end
            end
            MODE_CAPTURE, MODE_PWM: begin
                clear_counter = (state.counter == limit);
            end
        endcase

        // counting, pause and wrap
        if (enable_rise) begin
            next_state.counter = COUNTER_RESET; // see RL2
        end else if (state.ctrl0.timer_enable && !state.ctrl0.counter_pause && tick) begin
            if (clear_counter || state.counter == COUNTER_MAX) begin
                next_state.counter = COUNTER_RESET; // see RL24
            end else begin
                next_state.counter = state.counter + 10'h001; // see RL24
            end
        end // idle when disabled or paused, see RL3 and RL22

        // capture routing and trigger-edge clears
        cap_to_a = 1'b0;
        cap_to_b = 1'b0;
        if (state.ctrl1.op_mode_select == MODE_CAPTURE && state.ctrl0.timer_enable) begin
            if (state.ctrl2.capture_clear_select == 2'h0) begin
                unique case (state.ctrl1.pin_function_select) // see RL10
                    2'h0: cap_to_a = trig_rise;
                    2'h1: cap_to_a = trig_fall;
                    2'h2: cap_to_a = trig_rise || trig_fall;
                    2'h3: cap_to_a = 1'b0;
                endcase
            end else begin
                unique case (state.ctrl1.pin_function_select) // see RL11
                    2'h0: cap_to_b = trig_rise;
                    2'h1: cap_to_a = trig_fall;
                    2'h2: begin
                        cap_to_a = trig_fall;
                        cap_to_b = trig_rise;
                    end
                    2'h3: cap_to_a = 1'b0;
                endcase
            end
            if (cap_to_a) begin
                next_state.compare_a_value = state.counter;
            end
            if (cap_to_b) begin
                next_state.compare_b_value = state.counter;
            end
            if (cap_to_a || cap_to_b) begin
                next_state.ctrl2.latch_edge_flag = trig_rise; // see RL19
            end
            unique case (state.ctrl2.capture_clear_select) // see RL18
                2'h0: ;
                2'h1: if (trig_rise) next_state.counter = COUNTER_RESET;
                2'h2: if (trig_fall) next_state.counter = COUNTER_RESET;
                2'h3: if (trig_rise || trig_fall) next_state.counter = COUNTER_RESET;
            endcase
        end

        // output level before inversion
        pwm_active = (state.counter < state.compare_a_value)
            || (state.compare_a_value >= limit);
        if (enable_rise) begin
            next_state.out_level = state.ctrl1.output_initial_level; // see RL4 and RL14
        end else begin
            unique case (state.ctrl1.op_mode_select)
                MODE_COMPARE: begin
                    if (state.ctrl0.timer_enable && tick && match_a
                        && state.compare_a_value != COUNTER_RESET) begin
                        unique case (state.ctrl1.pin_function_select) // see RL8
                            2'h0: next_state.out_level = state.out_level;
                            2'h1: next_state.out_level = 1'b0;
                            2'h2: next_state.out_level = 1'b1;
                            2'h3: next_state.out_level = !state.out_level;
                        endcase
                    end
                end
                MODE_PWM: begin
                    unique case (state.ctrl1.pin_function_select) // see RL9
                        2'h0: next_state.out_level = !state.ctrl1.output_initial_level;
                        2'h1: next_state.out_level = state.ctrl1.output_initial_level;
                        2'h2: next_state.out_level = state.ctrl0.timer_enable && pwm_active
                            ? state.ctrl1.output_initial_level
                            : !state.ctrl1.output_initial_level; // see RL14
                        2'h3: next_state.out_level = state.ctrl0.timer_enable
                            ? state.ctrl1.output_initial_level
                            : !state.ctrl1.output_initial_level;
                    endcase
                end
                MODE_CAPTURE, MODE_TIMER: next_state.out_level = state.out_level;
            endcase
        end

        // single pulse ends on match a by clearing the enable bit
        if (state.ctrl1.op_mode_select == MODE_PWM && state.ctrl1.pin_function_select == 2'h3
            && state.ctrl0.timer_enable && tick && match_a) begin
            next_state.ctrl0.timer_enable = 1'b0;
        end

        // pin drive: released in timer/counter mode
        if (state.ctrl1.op_mode_select == MODE_TIMER) begin
            next_state.pin = 1'b0; // see RL7
            next_state.pin_oe = 1'b0; // see RL7
        end else begin
            next_state.pin = next_state.out_level ^ state.ctrl1.output_invert; // see RL15
            next_state.pin_oe = (state.ctrl1.op_mode_select != MODE_CAPTURE);
        end

        // apb read decode
        rd_ok = 1'b1;
        unique case (paddr)
            ADDR_CLOCK_ENABLE_CTRL: rd = {state.ctrl0, 3'h0};
            ADDR_MODE_OUTPUT_CTRL: rd = state.ctrl1;
            ADDR_CAPTURE_CLEAR_EDGE_CTRL: rd = {5'h00, state.ctrl2};
            ADDR_COUNTER_LOW: rd = lo_byte(state.counter); // see RL20
            ADDR_COUNTER_HIGH: rd = hi_byte(state.counter); // see RL20
            ADDR_COMPARE_A_LOW: rd = lo_byte(state.compare_a_value); // see RL21
            ADDR_COMPARE_A_HIGH: rd = hi_byte(state.compare_a_value);
            ADDR_COMPARE_B_LOW: rd = lo_byte(state.compare_b_value);
            ADDR_COMPARE_B_HIGH: rd = hi_byte(state.compare_b_value);
            ADDR_PERIOD_LOW: rd = lo_byte(state.period_value);
            ADDR_PERIOD_HIGH: rd = hi_byte(state.period_value);
            ADDR_INPUT_SOURCE_SELECT: rd = {7'h00, state.input_source_select_reg};
            default: begin
                rd = 8'h00;
                rd_ok = 1'b0;
            end
        endcase

        // answer is prepared in the setup cycle, ready in the first access cycle
        next_state.resp.pready = psel && !penable;
        next_state.resp.prdata = (psel && !penable && !pwrite) ? rd : 8'h00;
        next_state.resp.pslverr = psel && !penable && !rd_ok;

        // apb write at the completing access edge; software write wins over hardware
        wr = psel && penable && state.resp.pready && pwrite && rd_ok;
        if (wr) begin
            unique case (paddr)
                ADDR_CLOCK_ENABLE_CTRL: begin
                    next_state.ctrl0.counter_pause = pwdata[POS_PAUSE];
                    next_state.ctrl0.timer_clock_select =
                        ptc_clock_select_t'(pwdata[POS_CLOCK_SELECT +: 3]);
                    next_state.ctrl0.timer_enable = pwdata[POS_ENABLE];
                end
                ADDR_MODE_OUTPUT_CTRL: begin
                    next_state.ctrl1.op_mode_select = ptc_mode_t'(pwdata[POS_MODE +: 2]);
                    next_state.ctrl1.pin_function_select = pwdata[POS_PIN_FUNCTION +: 2];
                    next_state.ctrl1.output_initial_level = pwdata[POS_INITIAL_LEVEL];
                    next_state.ctrl1.output_invert = pwdata[POS_INVERT];
                    next_state.ctrl1.capture_source_select = pwdata[POS_CAPTURE_SOURCE];
                    next_state.ctrl1.counter_clear_select = pwdata[POS_CLEAR_SELECT];
                end
                ADDR_CAPTURE_CLEAR_EDGE_CTRL: begin
                    next_state.ctrl2.capture_clear_select = pwdata[POS_CAPTURE_CLEAR +: 2];
                end
                ADDR_COMPARE_A_LOW: next_state.compare_a_value[7:0] = pwdata[7:0]; // see RL21
                ADDR_COMPARE_A_HIGH: next_state.compare_a_value[9:8] = pwdata[1:0];
                ADDR_COMPARE_B_LOW: next_state.compare_b_value[7:0] = pwdata[7:0];
                ADDR_COMPARE_B_HIGH: next_state.compare_b_value[9:8] = pwdata[1:0];
                ADDR_PERIOD_LOW: next_state.period_value[7:0] = pwdata[7:0];
                ADDR_PERIOD_HIGH: next_state.period_value[9:8] = pwdata[1:0];
                ADDR_INPUT_SOURCE_SELECT: next_state.input_source_select_reg = pwdata[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flip-flops
    assign prdata = {24'h000000, state.resp.prdata};
    assign pready = state.resp.pready;
    assign pslverr = state.resp.pslverr;
    assign timer_output_pin = state.pin;
    assign timer_output_oe = state.pin_oe;

endmodule : ptc_timer

/* shared/ptc_pkg.sv */
// Summary of operation
// RL1: three-bit select picks counter clock source
// RL2: enable rise zeroes counter, fall holds it
// RL3: counter idle while enable bit is low
// RL4: enable rise loads initial output level
// RL5: two-bit field selects operating mode
// RL6: software stops timer before changing mode
// RL7: timer/counter mode ignores output level controls
// RL8: compare match A drives pin per function
// RL9: pwm mode pin function picks waveform
// RL10: capture clear 00 latches into compare A
// RL11: nonzero capture clear routes edges A/B
// RL12: software picks match level unlike initial
// RL13: pwm pin function changed only while off
// RL14: initial level bit sets level or polarity
// RL15: invert bit inverts output, not timer mode
// RL16: capture source bit picks trigger pin
// RL17: clear select picks match A or P
// RL18: capture clear select adds trigger edge clears
// RL19: flag shows edge of last latch
// RL20: counter readable as low and high byte
// RL21: compare A low byte, resets zero
// RL22: pause bit freezes counter while powered
// RL23: two comparators watch counter continuously
// RL24: counter increments per tick, wraps at 1023
package ptc_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_CLOCK_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE_OUTPUT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CAPTURE_CLEAR_EDGE_CTRL = 8'h08;
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h0C;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_A_LOW = 8'h14;
    localparam logic [7:0] ADDR_COMPARE_A_HIGH = 8'h18;
    localparam logic [7:0] ADDR_COMPARE_B_LOW = 8'h1C;
    localparam logic [7:0] ADDR_COMPARE_B_HIGH = 8'h20;
    localparam logic [7:0] ADDR_PERIOD_LOW = 8'h24;
    localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h28;
    localparam logic [7:0] ADDR_INPUT_SOURCE_SELECT = 8'h2C;

    // field positions inside the control bytes
    localparam int POS_PAUSE = 7;
    localparam int POS_CLOCK_SELECT = 4;
    localparam int POS_ENABLE = 3;
    localparam int POS_MODE = 6;
    localparam int POS_PIN_FUNCTION = 4;
    localparam int POS_INITIAL_LEVEL = 3;
    localparam int POS_INVERT = 2;
    localparam int POS_CAPTURE_SOURCE = 1;
    localparam int POS_CLEAR_SELECT = 0;
    localparam int POS_CAPTURE_CLEAR = 1;
    localparam int POS_EDGE_FLAG = 0;

    // reset values and counts
    localparam logic [9:0] COUNTER_RESET = 10'h000;
    localparam logic [9:0] COUNTER_MAX = 10'h3FF;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [5:0] DIV16_LAST = 6'h0F;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    localparam logic [7:0] SUB_DIV_LAST = 8'hF9;

    typedef enum logic [2:0] {
        CLK_SYS_DIV4 = 3'b000,
        CLK_SYS = 3'b001,
        CLK_HIGH_DIV16 = 3'b010,
        CLK_HIGH_DIV64 = 3'b011,
        CLK_SUB_A = 3'b100,
        CLK_SUB_B = 3'b101,
        CLK_EXT_RISE = 3'b110,
        CLK_EXT_FALL = 3'b111
    } ptc_clock_select_t;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } ptc_mode_t;

    typedef struct packed {
        logic counter_pause;
        ptc_clock_select_t timer_clock_select;
        logic timer_enable;
    } ptc_ctrl0_t;

    typedef struct packed {
        ptc_mode_t op_mode_select;
        logic [1:0] pin_function_select;
        logic output_initial_level;
        logic output_invert;
        logic capture_source_select;
        logic counter_clear_select;
    } ptc_ctrl1_t;

    typedef struct packed {
        logic [1:0] capture_clear_select;
        logic latch_edge_flag;
    } ptc_ctrl2_t;

    typedef struct packed {
        logic [7:0] prdata;
        logic pready;
        logic pslverr;
    } ptc_apb_resp_t;

endpackage : ptc_pkg

/* sim/ptc_timer_asserts.sv */
module ptc_timer_asserts
    import ptc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic timer_output_oe
);
    logic [1:0] mode_q;
    logic [1:0] age;
    logic en_q;
    logic lvl_q;
    logic wr_go;
    logic en_rise;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    // mode, enable and start level as written on the bus
    assign wr_go = psel && penable && pready && pwrite;
    assign en_rise = wr_go && paddr == ADDR_CLOCK_ENABLE_CTRL && pwdata[POS_ENABLE]
        && !en_q && mode_q == 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            age <= 2'h0;
            en_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            if (wr_go && paddr == ADDR_MODE_OUTPUT_CTRL) begin
                mode_q <= pwdata[7:6];
                lvl_q <= pwdata[POS_INITIAL_LEVEL] ^ pwdata[POS_INVERT];
            end
            if (wr_go && paddr == ADDR_CLOCK_ENABLE_CTRL) begin
                en_q <= pwdata[POS_ENABLE];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // bus answers and pin behaviour
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    error_answer_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without clean answer");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    count_high_a: assert property (pready && !pwrite && paddr == ADDR_COUNTER_HIGH
        |-> prdata[31:2] == 30'h0) else $error("counter high byte spare bits set");
    flag_byte_a: assert property (pready && !pwrite
        && paddr == ADDR_CAPTURE_CLEAR_EDGE_CTRL |-> prdata[31:3] == 29'h0)
        else $error("clear control spare bits set");
    timer_oe_off_a: assert property (mode_q == 2'h3 && $past(mode_q) == 2'h3
        |-> !timer_output_oe) else $error("pin driven in timer mode");
    capture_oe_off_a: assert property (mode_q == 2'h1 && $past(mode_q) == 2'h1
        |-> !timer_output_oe) else $error("pin driven in capture mode");
    compare_oe_on_a: assert property (age == 2'h3 && mode_q == 2'h0
        && $past(mode_q) == 2'h0 |-> timer_output_oe) else $error("pin idle in compare mode");
    enable_level_a: assert property (en_rise |-> ##[1:2] timer_output_pin == lvl_q)
        else $error("start level not loaded");

    cover property (pslverr);
    cover property (en_rise);
    cover property (mode_q == 2'h3 && !timer_output_oe);
endmodule : ptc_timer_asserts

bind ptc_timer ptc_timer_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_oe(timer_output_oe));

/* sim/ptc_pins_model.sv */
module ptc_pins_model (
    input wire logic pclk,
    output logic ext_clock_pin,
    output logic capture_input_pin,
    output logic line_comparator_out
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////
    // pins idle low until a scenario moves them
    initial begin
        {ext_clock_pin, capture_input_pin, line_comparator_out} = 3'h0;
    end

    // n clock pulses, two cycles high and two low
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            ext_clock_pin <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_clock_pin <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : pulses

    // move one trigger line, then wait four cycles
    task automatic trig(input logic to_line, input logic lvl);
        if (to_line) begin
            line_comparator_out <= lvl;
        end else begin
            capture_input_pin <= lvl;
        end
        repeat (4) @(posedge pclk);
    endtask : trig
endmodule : ptc_pins_model

/* sim/testbench.sv */
module testbench
    import ptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_clock_pin;
    logic capture_input_pin;
    logic line_comparator_out;
    logic timer_output_pin;
    logic timer_output_oe;
    int errors = 0;
    int checks = 0;
    logic [31:0] rsp_data;
    logic rsp_err;

    ptc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
        .capture_input_pin(capture_input_pin), .line_comparator_out(line_comparator_out),
        .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe));
    ptc_pins_model pins (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
        .capture_input_pin(capture_input_pin), .line_comparator_out(line_comparator_out));

    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////
    // shared helpers
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // one bus transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rsp_data = prdata;
        rsp_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        apb(1'b0, a, 8'h00);
        check(rsp_data, {24'h0, want});
    endtask : rd

    // stop, set mode, start
    task automatic restart(input logic [7:0] mode);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'h60);
        wr(ADDR_MODE_OUTPUT_CTRL, mode);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'h68);
    endtask : restart

    ////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_regs();
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        wr(ADDR_COMPARE_A_LOW, 8'hA5);
        rd(ADDR_COMPARE_A_LOW, 8'hA5);
        wr(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h07);
        rd(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h06);
        wr(ADDR_COUNTER_LOW, 8'hFF);
        wr(ADDR_COUNTER_HIGH, 8'hFF);
        rd(ADDR_COUNTER_LOW, 8'h00);
        rd(ADDR_COUNTER_HIGH, 8'h00);
        apb(1'b0, 8'h30, 8'h00);
        check({31'h0, rsp_err}, 32'h1);
        wr(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h00);
        $display("test regs done");
    endtask : test_regs

    task automatic test_count();
        restart(8'hC0);
        repeat (3) @(posedge pclk);
        check({31'h0, timer_output_oe}, 32'h0);
        pins.pulses(5);
        rd(ADDR_COUNTER_LOW, 8'h05);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'hE8);
        pins.pulses(3);
        rd(ADDR_COUNTER_LOW, 8'h05);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'h68);
        pins.pulses(2);
        rd(ADDR_COUNTER_LOW, 8'h07);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'h60);
        pins.pulses(2);
        rd(ADDR_COUNTER_LOW, 8'h07);
        wr(ADDR_CLOCK_ENABLE_CTRL, 8'h78);
        rd(ADDR_COUNTER_LOW, 8'h00);
        pins.pulses(1020);
        rd(ADDR_COUNTER_LOW, 8'hFC);
        rd(ADDR_COUNTER_HIGH, 8'h03);
        pins.pulses(4);
        rd(ADDR_COUNTER_HIGH, 8'h00);
        $display("test count done");
    endtask : test_count

    // pin actions on match A, then the four pwm pin functions
    task automatic test_pin();
        logic ocl;
        logic pol;
        logic lvl;
        wr(ADDR_COMPARE_A_LOW, 8'h03);
        for (int f = 0; f < 4; f++) begin
            ocl = (f == 1);
            pol = (f == 2);
            lvl = (f == 0) ? ocl : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : !ocl;
            restart({2'h0, 2'(f), ocl, pol, 2'h0});
            repeat (3) @(posedge pclk);
            check({31'h0, timer_output_pin}, {31'h0, ocl ^ pol});
            pins.pulses(4);
            check({31'h0, timer_output_pin}, {31'h0, lvl ^ pol});
        end
        for (int f = 0; f < 4; f++) begin
            restart({2'h2, 2'(f), 4'h8});
            repeat (3) @(posedge pclk);
            check({31'h0, timer_output_pin}, 32'(f != 0));
            pins.pulses(4);
            check({31'h0, timer_output_pin}, 32'(f == 1));
        end
        $display("test pin done");
    endtask : test_pin

    task automatic test_capture();
        restart(8'h40);
        pins.pulses(5);
        pins.trig(1'b0, 1'b1);
        rd(ADDR_COMPARE_A_LOW, 8'h05);
        restart(8'h70);
        pins.pulses(2);
        pins.trig(1'b0, 1'b0);
        pins.trig(1'b0, 1'b1);
        rd(ADDR_COMPARE_A_LOW, 8'h05);
        wr(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h04);
        restart(8'h60);
        pins.pulses(2);
        pins.trig(1'b0, 1'b0);
        rd(ADDR_COMPARE_A_LOW, 8'h02);
        rd(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h04);
        rd(ADDR_COUNTER_LOW, 8'h00);
        pins.pulses(3);
        pins.trig(1'b0, 1'b1);
        rd(ADDR_COMPARE_B_LOW, 8'h03);
        rd(ADDR_CAPTURE_CLEAR_EDGE_CTRL, 8'h05);
        rd(ADDR_COUNTER_LOW, 8'h03);
        pins.trig(1'b0, 1'b0);
        wr(ADDR_INPUT_SOURCE_SELECT, 8'h01);
        pins.pulses(2);
        pins.trig(1'b1, 1'b1);
        rd(ADDR_COMPARE_B_LOW, 8'h02);
        $display("test capture done");
    endtask : test_capture

    ////////////////////////////////////////////////////////////
    // main sequence and hang guard
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_regs();
        test_count();
        test_pin();
        test_capture();
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        end_of_test();
    end
endmodule : testbench
